// [rtl/nia_aggregator.sv]
// nia_aggregator: apb slave gathering sources into one normal request
// assumes apb master on pclk; source levels synchronous to pclk
//
// Notes on behaviour
// - accept 23 sources incl. four external pins
// - each source has its own mask bit
// - fixed bit positions; bit 0 unused here
// - bit 23 is motor-drive trip event
// - status equals raw AND enable
// - request output is OR of status
// - no priority encoder, no vector
// - raw register mirrors source levels unmasked
// - enable one passes source, zero masks
// - enable writes only set bits
// - clear register clears bits written one
// - four 32-bit registers in the set
`timescale 1ns/1ps
module nia_aggregator (
  input wire logic pclk,
  input wire logic presetn,
  input wire nia_pkg::nia_apb_req_t apb_req,
  output nia_pkg::nia_apb_rsp_t apb_rsp,
  input wire logic software_interrupt,
  input wire logic [12:0] periph_req,
  input wire logic external_request_pin_0,
  input wire logic external_request_pin_1,
  input wire logic external_request_pin_2,
  input wire logic external_request_pin_3,
  input wire logic comparator_req,
  input wire logic supply_monitor,
  input wire logic [1:0] programmable_logic_array,
  input wire logic motor_trip,
  output logic normal_irq
);
  logic [31:0] raw_source_signal;
  logic [31:0] source_enable_mask_q;
  logic [31:0] enabled_pending_status;
  logic [31:0] rdata_q;
  logic slverr_q;
  logic access;
  logic wr_en;
  logic wr_clr;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // source packing; bits 0 and 24..31 carry no source
  always_comb begin
    raw_source_signal = nia_pkg::ZERO_WORD;
    raw_source_signal[nia_pkg::BIT_SOFTWARE] = software_interrupt;
    raw_source_signal[nia_pkg::BIT_EXT0-1:nia_pkg::BIT_FIRST_PERIPH] = periph_req;
    raw_source_signal[nia_pkg::BIT_EXT0] = external_request_pin_0;
    raw_source_signal[nia_pkg::BIT_COMPARATOR] = comparator_req;
    raw_source_signal[nia_pkg::BIT_SUPPLY] = supply_monitor;
    raw_source_signal[nia_pkg::BIT_EXT1] = external_request_pin_1;
    raw_source_signal[nia_pkg::BIT_PLA_HI:nia_pkg::BIT_PLA_LO] = programmable_logic_array;
    raw_source_signal[nia_pkg::BIT_EXT2] = external_request_pin_2;
    raw_source_signal[nia_pkg::BIT_EXT3] = external_request_pin_3;
    raw_source_signal[nia_pkg::BIT_MOTOR_TRIP] = motor_trip;
  end

  // per-bit masking; no priority, no vector
  assign enabled_pending_status = raw_source_signal & source_enable_mask_q;
  assign normal_irq = |enabled_pending_status;

  assign access = apb_req.psel && apb_req.penable;
  assign wr_en = access && apb_req.pwrite && hit(apb_req.paddr, nia_pkg::OFF_ENABLE);
  assign wr_clr = access && apb_req.pwrite && hit(apb_req.paddr, nia_pkg::OFF_CLEAR);

  // enable mask: writes set, clear register clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_enable_mask_q <= nia_pkg::ENABLE_RESET;
    end else if (wr_en) begin
      source_enable_mask_q <= source_enable_mask_q | apb_req.pwdata;
    end else if (wr_clr) begin
      source_enable_mask_q <= source_enable_mask_q & ~apb_req.pwdata;
    end
  end

  // read data captured in setup phase, presented in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= nia_pkg::ZERO_WORD;
      slverr_q <= 1'b0;
    end else if (apb_req.psel && !apb_req.penable) begin
      rdata_q <= nia_pkg::ZERO_WORD;
      slverr_q <= 1'b0;
      if (hit(apb_req.paddr, nia_pkg::OFF_STATUS)) begin
        if (!apb_req.pwrite) rdata_q <= enabled_pending_status;
        else slverr_q <= 1'b1;
      end else if (hit(apb_req.paddr, nia_pkg::OFF_RAW)) begin
        if (!apb_req.pwrite) rdata_q <= raw_source_signal;
        else slverr_q <= 1'b1;
      end else if (hit(apb_req.paddr, nia_pkg::OFF_ENABLE)) begin
        if (!apb_req.pwrite) rdata_q <= source_enable_mask_q;
      end else if (hit(apb_req.paddr, nia_pkg::OFF_CLEAR)) begin
        if (!apb_req.pwrite) slverr_q <= 1'b1;
      end else begin
        slverr_q <= 1'b1;
      end
    end
  end

  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = slverr_q && access;
    apb_rsp.prdata = rdata_q;
  end

  property p_irq_or;
    @(posedge pclk) disable iff (!presetn)
      normal_irq == ((raw_source_signal & source_enable_mask_q) != nia_pkg::ZERO_WORD);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("request not or of status");

  property p_set_only;
    @(posedge pclk) disable iff (!presetn)
      wr_en |=> ((source_enable_mask_q & $past(source_enable_mask_q))
                 == $past(source_enable_mask_q));
  endproperty
  a_set_only: assert property (p_set_only) else $error("enable write cleared a bit");

  property p_set_bits;
    @(posedge pclk) disable iff (!presetn)
      wr_en |=> ((source_enable_mask_q & $past(apb_req.pwdata)) == $past(apb_req.pwdata));
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("enable write missed a bit");

  property p_clear_bits;
    @(posedge pclk) disable iff (!presetn)
      wr_clr |=> ((source_enable_mask_q & $past(apb_req.pwdata)) == nia_pkg::ZERO_WORD)
        && ((source_enable_mask_q | $past(apb_req.pwdata))
            == ($past(source_enable_mask_q) | $past(apb_req.pwdata)));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear write wrong");

  property p_stable_mask;
    @(posedge pclk) disable iff (!presetn)
      !(wr_en || wr_clr) |=> $stable(source_enable_mask_q);
  endproperty
  a_stable_mask: assert property (p_stable_mask) else $error("mask changed unasked");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && !apb_req.pwrite
       && apb_req.paddr == nia_pkg::OFF_STATUS)
        |=> apb_rsp.prdata == $past(enabled_pending_status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_raw_read;
    @(posedge pclk) disable iff (!presetn)
      (apb_req.psel && !apb_req.penable && !apb_req.pwrite
       && apb_req.paddr == nia_pkg::OFF_RAW)
        |=> apb_rsp.prdata[nia_pkg::BIT_TOP:1] == $past(raw_source_signal[23:1]);
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw read wrong");

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[31:24] == 8'h00 && !raw_source_signal[nia_pkg::BIT_ALL_OR];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused source bit set");

  // bus phase sequences shared by the checks below
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  sequence s_setup_rd_enable;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == nia_pkg::OFF_ENABLE;
  endsequence

  sequence s_setup_rd_clear;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == nia_pkg::OFF_CLEAR;
  endsequence

  sequence s_setup_wr_status;
    apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == nia_pkg::OFF_STATUS;
  endsequence

  sequence s_setup_wr_raw;
    apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == nia_pkg::OFF_RAW;
  endsequence

  sequence s_setup_wr_enable;
    apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == nia_pkg::OFF_ENABLE;
  endsequence

  sequence s_setup_wr_clear;
    apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == nia_pkg::OFF_CLEAR;
  endsequence

  property p_enable_read;
    @(posedge pclk) disable iff (!presetn)
      s_setup_rd_enable |=> apb_rsp.prdata == $past(source_enable_mask_q);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

  property p_clear_read_err;
    @(posedge pclk) disable iff (!presetn)
      s_setup_rd_clear ##1 s_access |-> apb_rsp.pslverr;
  endproperty
  a_clear_read_err: assert property (p_clear_read_err) else $error("clear read not refused");

  property p_status_write_err;
    @(posedge pclk) disable iff (!presetn)
      s_setup_wr_status ##1 s_access |-> apb_rsp.pslverr;
  endproperty
  a_status_write_err: assert property (p_status_write_err) else $error("status write ok");

  property p_raw_write_err;
    @(posedge pclk) disable iff (!presetn)
      s_setup_wr_raw ##1 s_access |-> apb_rsp.pslverr;
  endproperty
  a_raw_write_err: assert property (p_raw_write_err) else $error("raw write not refused");

  property p_enable_write_ok;
    @(posedge pclk) disable iff (!presetn)
      s_setup_wr_enable ##1 s_access |-> !apb_rsp.pslverr;
  endproperty
  a_enable_write_ok: assert property (p_enable_write_ok) else $error("enable write refused");

  property p_clear_write_ok;
    @(posedge pclk) disable iff (!presetn)
      s_setup_wr_clear ##1 s_access |-> !apb_rsp.pslverr;
  endproperty
  a_clear_write_ok: assert property (p_clear_write_ok) else $error("clear write refused");

  property p_err_in_access;
    @(posedge pclk) disable iff (!presetn)
      !(apb_req.psel && apb_req.penable) |-> !apb_rsp.pslverr;
  endproperty
  a_err_in_access: assert property (p_err_in_access) else $error("error outside access");

  property p_ready_high;
    @(posedge pclk) disable iff (!presetn)
      s_access |-> apb_rsp.pready;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("access stalled");

  property p_rdata_holds;
    @(posedge pclk) disable iff (!presetn)
      !(apb_req.psel && !apb_req.penable) |=> $stable(apb_rsp.prdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");

  property p_status_and;
    @(posedge pclk) disable iff (!presetn)
      enabled_pending_status == (raw_source_signal & source_enable_mask_q);
  endproperty
  a_status_and: assert property (p_status_and) else $error("status not masked raw");

  property p_masked_quiet;
    @(posedge pclk) disable iff (!presetn)
      source_enable_mask_q == nia_pkg::ZERO_WORD |-> !normal_irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("request with no enable");

  property p_single_source;
    @(posedge pclk) disable iff (!presetn)
      (source_enable_mask_q[nia_pkg::BIT_SOFTWARE] && software_interrupt) |-> normal_irq;
  endproperty
  a_single_source: assert property (p_single_source) else $error("enabled source lost");

  property p_src_software;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_SOFTWARE] == software_interrupt;
  endproperty
  a_src_software: assert property (p_src_software) else $error("software bit wrong");

  property p_src_periph;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_EXT0-1:nia_pkg::BIT_FIRST_PERIPH] == periph_req;
  endproperty
  a_src_periph: assert property (p_src_periph) else $error("peripheral bits wrong");

  property p_src_ext0;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_EXT0] == external_request_pin_0;
  endproperty
  a_src_ext0: assert property (p_src_ext0) else $error("pin 0 bit wrong");

  property p_src_ext1;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_EXT1] == external_request_pin_1;
  endproperty
  a_src_ext1: assert property (p_src_ext1) else $error("pin 1 bit wrong");

  property p_src_ext2;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_EXT2] == external_request_pin_2;
  endproperty
  a_src_ext2: assert property (p_src_ext2) else $error("pin 2 bit wrong");

  property p_src_ext3;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_EXT3] == external_request_pin_3;
  endproperty
  a_src_ext3: assert property (p_src_ext3) else $error("pin 3 bit wrong");

  property p_src_comparator;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_COMPARATOR] == comparator_req;
  endproperty
  a_src_comparator: assert property (p_src_comparator) else $error("comparator bit wrong");

  property p_src_supply;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_SUPPLY] == supply_monitor;
  endproperty
  a_src_supply: assert property (p_src_supply) else $error("supply bit wrong");

  property p_src_logic;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_PLA_HI:nia_pkg::BIT_PLA_LO] == programmable_logic_array;
  endproperty
  a_src_logic: assert property (p_src_logic) else $error("logic array bits wrong");

  property p_src_motor;
    @(posedge pclk) disable iff (!presetn)
      raw_source_signal[nia_pkg::BIT_MOTOR_TRIP] == motor_trip;
  endproperty
  a_src_motor: assert property (p_src_motor) else $error("trip bit wrong");
endmodule

// [rtl/nia_pkg.sv]
// nia_pkg: register map, source bit positions and bus types for the
// normal interrupt aggregator; assumes a 32-bit apb master outside
package nia_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned NUM_SRC = 23;
  localparam logic [31:0] OFF_STATUS = 32'hffff_0000;
  localparam logic [31:0] OFF_RAW = 32'hffff_0004;
  localparam logic [31:0] OFF_ENABLE = 32'hffff_0008;
  localparam logic [31:0] OFF_CLEAR = 32'hffff_000c;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // fixed source positions
  localparam int unsigned BIT_ALL_OR = 0;
  localparam int unsigned BIT_SOFTWARE = 1;
  localparam int unsigned BIT_FIRST_PERIPH = 2;
  localparam int unsigned BIT_EXT0 = 15;
  localparam int unsigned BIT_COMPARATOR = 16;
  localparam int unsigned BIT_SUPPLY = 17;
  localparam int unsigned BIT_EXT1 = 18;
  localparam int unsigned BIT_PLA_LO = 19;
  localparam int unsigned BIT_PLA_HI = 20;
  localparam int unsigned BIT_EXT2 = 21;
  localparam int unsigned BIT_EXT3 = 22;
  localparam int unsigned BIT_MOTOR_TRIP = 23;
  localparam int unsigned BIT_TOP = 23;
  // bits 24..31 carry no source and read as zero in raw and status; enable keeps what is written there

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } nia_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } nia_apb_rsp_t;
endpackage

// [testbench/nia_core_model.sv]
// nia_core_model: core side of the normal request line
// assumes the request is a level on the core clock
`timescale 1ns/1ps
module nia_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic normal_irq,
  output logic irq_seen_q
);
  // core samples the level request once a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_seen_q <= 1'b0;
    end else begin
      irq_seen_q <= normal_irq;
    end
  end
endmodule

// [testbench/normal_interrupt_aggregator_tb.sv]
// normal_interrupt_aggregator_tb: apb tests of the normal request set
// assumes nia_pkg and nia_aggregator compiled first
`timescale 1ns/1ps
module normal_interrupt_aggregator_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [31:0] src = 32'h0000_0000;
  logic [31:0] rd;
  logic err;
  logic irq;
  logic seen;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  nia_pkg::nia_apb_req_t req = '0;
  nia_pkg::nia_apb_rsp_t rsp;
  always #20 pclk = ~pclk;
  nia_aggregator uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .software_interrupt(src[1]), .periph_req(src[14:2]), .external_request_pin_0(src[15]),
    .external_request_pin_1(src[18]), .external_request_pin_2(src[21]),
    .external_request_pin_3(src[22]), .comparator_req(src[16]), .supply_monitor(src[17]),
    .programmable_logic_array(src[20:19]), .motor_trip(src[23]), .normal_irq(irq));
  nia_core_model core (.pclk(pclk), .presetn(presetn), .normal_irq(irq), .irq_seen_q(seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // the core model lags the request line by one clock
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge pclk);
    chk({31'h0000_0000, seen}, {31'h0000_0000, exp});
  endtask
  task automatic t_reset();
    src <= 32'h00ff_fffe;
    rdchk(nia_pkg::OFF_STATUS, 32'h0000_0000);
    rdchk(nia_pkg::OFF_ENABLE, 32'h0000_0000);
    irqchk(1'b0);
    $display("test reset done");
  endtask
  task automatic t_mask();
    apb(1'b1, nia_pkg::OFF_ENABLE, 32'h0000_0006);
    rdchk(nia_pkg::OFF_ENABLE, 32'h0000_0006);
    rdchk(nia_pkg::OFF_STATUS, 32'h0000_0006);
    rdchk(nia_pkg::OFF_RAW, 32'h00ff_fffe);
    irqchk(1'b1);
    apb(1'b1, nia_pkg::OFF_ENABLE, 32'h0000_0000);
    rdchk(nia_pkg::OFF_ENABLE, 32'h0000_0006);
    apb(1'b1, nia_pkg::OFF_CLEAR, 32'h0000_0002);
    rdchk(nia_pkg::OFF_ENABLE, 32'h0000_0004);
    src <= 32'h00ff_fffa;
    rdchk(nia_pkg::OFF_STATUS, 32'h0000_0000);
    rdchk(nia_pkg::OFF_RAW, 32'h00ff_fffa);
    irqchk(1'b0);
    $display("test mask done");
  endtask
  task automatic t_bits();
    src <= 32'h00ff_fffe;
    apb(1'b1, nia_pkg::OFF_CLEAR, 32'hffff_ffff);
    for (int i = 1; i < 24; i++) begin
      apb(1'b1, nia_pkg::OFF_ENABLE, 32'h0000_0001 << i);
      rdchk(nia_pkg::OFF_STATUS, 32'h0000_0001 << i);
      apb(1'b1, nia_pkg::OFF_CLEAR, 32'h0000_0001 << i);
    end
    apb(1'b1, nia_pkg::OFF_ENABLE, 32'hffff_ffff);
    rdchk(nia_pkg::OFF_STATUS, 32'h00ff_fffe);
    $display("test bits done");
  endtask
  task automatic t_err();
    apb(1'b0, nia_pkg::OFF_CLEAR, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, nia_pkg::OFF_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, nia_pkg::OFF_RAW, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b0, 32'hffff_0010, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    rdchk(nia_pkg::OFF_ENABLE, 32'hffff_ffff);
    chk({31'h0000_0000, err}, 32'h0000_0000);
    rdchk(nia_pkg::OFF_STATUS, 32'h00ff_fffe);
    $display("test errors done");
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_bits();
    t_err();
    finish_test();
  end
endmodule
